//--- logic/dcf_fifo.sv
// Dual-clock FIFO with per-side flags, pointers and an Avalon-MM control slave
//
// Behaviour
// - A write lands in the location the write pointer names; that is the first one after reset, after flush and after each wrap.
// - Empty falls three read edges after the first write, four in fall-through mode.
// - Fall-through mode shows the first word unasked; standard mode only after a read.
// - A write edge close to a read edge may delay the fall of empty by one read edge.
// - Write data, parity and enable are held stable by the writer and sampled on a write edge.
// - Read enable is held stable by the reader and sampled only on a read edge.
// - Read data and read parity change together on a read edge.
// - Near-empty, empty, read error and read pointer are registered on read edges.
// - Near-full, full, write error and write pointer are registered on write edges.
// - Reset forces all flags and both pointers to reset values regardless of either side clock.
// - A write while full raises write error for that edge and drops the word.
// - A read with no data raises read error; read data is left unchanged unless fall-through mode loads a word on that same edge.
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo #(
	parameter int DATA_W          = 32,
	parameter int PAR_W           = 4,
	parameter int ADDR_W          = 9,
	parameter int NEAR_EMPTY_OFFS = 4,
	parameter int NEAR_FULL_OFFS  = 4,
	parameter bit first_word_fallthrough_mode = 1'b0
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        write_side_clock,
	input  wire logic [DATA_W-1:0]           write_data_in,
	input  wire logic [PAR_W-1:0]            write_parity_in,
	input  wire logic                        write_enable_in,
	input  wire logic                        read_side_clock,
	input  wire logic                        read_enable_in,
	output logic      [DATA_W-1:0]           read_data_out,
	output logic      [PAR_W-1:0]            read_parity_out,
	output logic                             empty_flag,
	output logic                             near_empty_flag,
	output logic                             full_flag,
	output logic                             near_full_flag,
	output logic                             read_underflow_flag,
	output logic                             write_overflow_flag,
	output logic      [dcf_pkg::COUNT_W-1:0] read_pointer_out,
	output logic      [dcf_pkg::COUNT_W-1:0] write_pointer_out,
	input  wire logic [4:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	output logic                             irq
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int PTR_W = ADDR_W + 1;
	localparam int WORD_W = DATA_W + PAR_W;
	localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
	localparam logic [PTR_W-1:0] NEAR_E_P = PTR_W'(NEAR_EMPTY_OFFS);
	localparam logic [PTR_W-1:0] NEAR_F_P = PTR_W'(DEPTH - NEAR_FULL_OFFS);

	typedef struct packed {
		logic                         wclk_prev;
		logic                         rclk_prev;
		logic [DEPTH-1:0][WORD_W-1:0] mem;
		logic [PTR_W-1:0]             wptr;
		logic [PTR_W-1:0]             wgray;
		logic                         full;
		logic                         near_full;
		logic                         wr_err;
		logic [PTR_W-1:0]             rptr;
		logic [PTR_W-1:0]             rgray;
		logic                         int_empty;
		logic                         out_valid;
		logic                         near_empty;
		logic                         rd_err;
		logic [DATA_W-1:0]            rdata;
		logic [PAR_W-1:0]             rpar;
		logic                         flush;
		logic [dcf_pkg::IRQ_W-1:0]    irq_stat;
		logic [dcf_pkg::IRQ_W-1:0]    irq_en;
		logic                         ack;
		logic [31:0]                  rdbus;
	} dcf_state_s;

	dcf_state_s s_q;
	dcf_state_s s_d;

	logic [PTR_W-1:0] wgray_at_rd;
	logic [PTR_W-1:0] rgray_at_wr;
	logic             fifo_rst;

	// ==========================================================
	// Helpers
	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b = '0;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p, input logic inc);
		return p + {{(PTR_W-1){1'b0}}, inc};
	endfunction

	// Flush holds the FIFO in reset; register block keeps its state
	assign fifo_rst = reset | s_q.flush;

	// ==========================================================
	// Pointer crossings
	dcf_sync #(
		.W(PTR_W)
	) u_wr_to_rd (
		.core_clk(core_clk),
		.reset   (fifo_rst),
		.step    (read_side_clock & ~s_q.rclk_prev),
		.d       (s_q.wgray),
		.q       (wgray_at_rd)
	);

	dcf_sync #(
		.W(PTR_W)
	) u_rd_to_wr (
		.core_clk(core_clk),
		.reset   (fifo_rst),
		.step    (write_side_clock & ~s_q.wclk_prev),
		.d       (s_q.rgray),
		.q       (rgray_at_wr)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic                      wr_edge;
		logic                      rd_edge;
		logic                      push;
		logic                      pop;
		logic                      ren_err;
		logic [PTR_W-1:0]          wptr_n;
		logic [PTR_W-1:0]          rptr_n;
		logic [PTR_W-1:0]          wlevel;
		logic [PTR_W-1:0]          rlevel;
		logic [dcf_pkg::IRQ_W-1:0] ev;
		logic [dcf_pkg::IRQ_W-1:0] clr;
		logic                      wr_take;
		logic                      empty_now;
		logic                      empty_next;
		s_d = s_q;
		wr_edge = write_side_clock & ~s_q.wclk_prev;
		rd_edge = read_side_clock & ~s_q.rclk_prev;
		push = 1'b0;
		pop = 1'b0;
		ren_err = 1'b0;
		wptr_n = s_q.wptr;
		rptr_n = s_q.rptr;
		wlevel = '0;
		rlevel = '0;
		ev = '0;
		clr = '0;
		wr_take = avs_write & s_q.ack;
		empty_now = first_word_fallthrough_mode ? ~s_q.out_valid : s_q.int_empty;
		empty_next = empty_now;
		s_d.wclk_prev = write_side_clock;
		s_d.rclk_prev = read_side_clock;

		// Write side: inputs are looked at only on a write edge
		if (wr_edge) begin
			push = write_enable_in & ~s_q.full;
			if (push) begin
				s_d.mem[s_q.wptr[ADDR_W-1:0]] = {write_data_in, write_parity_in};
			end
			wptr_n = step(s_q.wptr, push);
			wlevel = wptr_n - gray2bin(rgray_at_wr);
			s_d.wptr = wptr_n;
			s_d.wgray = bin2gray(wptr_n);
			s_d.full = (wlevel == DEPTH_P);
			s_d.near_full = (wlevel >= NEAR_F_P);
			s_d.wr_err = write_enable_in & s_q.full;
			ev[dcf_pkg::IRQ_OVERFLOW] = write_enable_in & s_q.full;
			ev[dcf_pkg::IRQ_BECAME_FULL] = ~s_q.full & (wlevel == DEPTH_P);
		end

		// Read side: read enable is looked at only on a read edge
		if (rd_edge) begin
			if (first_word_fallthrough_mode) begin
				pop = ~s_q.int_empty & (~s_q.out_valid | read_enable_in);
				ren_err = read_enable_in & ~s_q.out_valid;
			end else begin
				pop = read_enable_in & ~s_q.int_empty;
				ren_err = read_enable_in & s_q.int_empty;
			end
			if (pop) begin
				{s_d.rdata, s_d.rpar} = s_q.mem[s_q.rptr[ADDR_W-1:0]];
				s_d.out_valid = 1'b1;
			end else if (read_enable_in) begin
				s_d.out_valid = 1'b0;
			end
			rptr_n = step(s_q.rptr, pop);
			rlevel = gray2bin(wgray_at_rd) - rptr_n;
			s_d.rptr = rptr_n;
			s_d.rgray = bin2gray(rptr_n);
			// Registered from the second sync stage: three read edges after the write
			s_d.int_empty = (rlevel == '0);
			s_d.near_empty = (rlevel <= NEAR_E_P);
			s_d.rd_err = ren_err;
			empty_next = first_word_fallthrough_mode ? ~s_d.out_valid : s_d.int_empty;
			ev[dcf_pkg::IRQ_UNDERFLOW] = ren_err;
			ev[dcf_pkg::IRQ_DATA_READY] = empty_now & ~empty_next;
		end

		// Register slave: one wait cycle, effect and data at the released edge
		s_d.ack = (avs_read | avs_write) & ~s_q.ack;
		if (s_d.ack) begin
			s_d.rdbus = '0;
			case (avs_address)
				dcf_pkg::REG_CTRL: begin
					s_d.rdbus[dcf_pkg::CTRL_FLUSH_BIT] = s_q.flush;
				end
				dcf_pkg::REG_FLAGS: begin
					s_d.rdbus[dcf_pkg::FLG_EMPTY] = empty_now;
					s_d.rdbus[dcf_pkg::FLG_NEAR_EMPTY] = s_q.near_empty;
					s_d.rdbus[dcf_pkg::FLG_FULL] = s_q.full;
					s_d.rdbus[dcf_pkg::FLG_NEAR_FULL] = s_q.near_full;
					s_d.rdbus[dcf_pkg::FLG_RD_ERR] = s_q.rd_err;
					s_d.rdbus[dcf_pkg::FLG_WR_ERR] = s_q.wr_err;
				end
				dcf_pkg::REG_POINTERS: begin
					s_d.rdbus[dcf_pkg::PTR_FIELD_W-1:0] = dcf_pkg::PTR_FIELD_W'(s_q.rptr);
					s_d.rdbus[dcf_pkg::PTR_WR_LSB +: dcf_pkg::PTR_FIELD_W] =
						dcf_pkg::PTR_FIELD_W'(s_q.wptr);
				end
				dcf_pkg::REG_IRQ_STATUS: begin
					s_d.rdbus[dcf_pkg::IRQ_W-1:0] = s_q.irq_stat;
				end
				dcf_pkg::REG_IRQ_ENABLE: begin
					s_d.rdbus[dcf_pkg::IRQ_W-1:0] = s_q.irq_en;
				end
				default: begin
					s_d.rdbus = '0;
				end
			endcase
		end
		if (wr_take & avs_byteenable[0]) begin
			case (avs_address)
				dcf_pkg::REG_CTRL: begin
					s_d.flush = avs_writedata[dcf_pkg::CTRL_FLUSH_BIT];
				end
				dcf_pkg::REG_IRQ_ENABLE: begin
					s_d.irq_en = avs_writedata[dcf_pkg::IRQ_W-1:0];
				end
				dcf_pkg::REG_IRQ_CLEAR: begin
					clr = avs_writedata[dcf_pkg::IRQ_W-1:0];
				end
				default: begin
					clr = '0;
				end
			endcase
		end
		// A new event in the clearing cycle survives the clear
		s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;

		// FIFO reset ignores both side clocks; memory contents are left alone
		if (fifo_rst) begin
			s_d.wptr = '0;
			s_d.wgray = '0;
			s_d.rptr = '0;
			s_d.rgray = '0;
			s_d.full = dcf_pkg::RST_FULL;
			s_d.near_full = dcf_pkg::RST_NEAR_FULL;
			s_d.wr_err = dcf_pkg::RST_ERR;
			s_d.rd_err = dcf_pkg::RST_ERR;
			s_d.int_empty = dcf_pkg::RST_EMPTY;
			s_d.near_empty = dcf_pkg::RST_NEAR_EMPTY;
			s_d.out_valid = 1'b0;
			s_d.rdata = '0;
			s_d.rpar = '0;
			// Side clocks high at release would otherwise count as an edge
			s_d.wclk_prev = dcf_pkg::RST_CLK_PREV;
			s_d.rclk_prev = dcf_pkg::RST_CLK_PREV;
		end
		if (reset) begin
			s_d.flush = 1'b0;
			s_d.irq_stat = '0;
			s_d.irq_en = '0;
			s_d.ack = 1'b0;
			s_d.rdbus = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		s_q <= s_d;
	end

	// ==========================================================
	// Outputs
	assign read_data_out = s_q.rdata;
	assign read_parity_out = s_q.rpar;
	assign empty_flag = first_word_fallthrough_mode ? ~s_q.out_valid : s_q.int_empty;
	assign near_empty_flag = s_q.near_empty;
	assign full_flag = s_q.full;
	assign near_full_flag = s_q.near_full;
	assign read_underflow_flag = s_q.rd_err;
	assign write_overflow_flag = s_q.wr_err;
	assign read_pointer_out = dcf_pkg::COUNT_W'(s_q.rptr);
	assign write_pointer_out = dcf_pkg::COUNT_W'(s_q.wptr);
	assign avs_readdata = s_q.rdbus;
	assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
	assign irq = |(s_q.irq_stat & s_q.irq_en);

endmodule
`default_nettype wire

//--- logic/dcf_pkg.sv
// Constants shared by the dual-clock flag-timing FIFO
package dcf_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] REG_CTRL       = 5'h00;
	localparam logic [4:0] REG_FLAGS      = 5'h04;
	localparam logic [4:0] REG_POINTERS   = 5'h08;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h0c;
	localparam logic [4:0] REG_IRQ_ENABLE = 5'h10;
	localparam logic [4:0] REG_IRQ_CLEAR  = 5'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_FLUSH_BIT  = 0;
	localparam int FLG_EMPTY       = 0;
	localparam int FLG_NEAR_EMPTY  = 1;
	localparam int FLG_FULL        = 2;
	localparam int FLG_NEAR_FULL   = 3;
	localparam int FLG_RD_ERR      = 4;
	localparam int FLG_WR_ERR      = 5;
	localparam int PTR_FIELD_W     = 16;
	localparam int PTR_WR_LSB      = 16;

	// ==========================================================
	// Interrupt event bits
	localparam int IRQ_W           = 4;
	localparam int IRQ_OVERFLOW    = 0;
	localparam int IRQ_UNDERFLOW   = 1;
	localparam int IRQ_BECAME_FULL = 2;
	localparam int IRQ_DATA_READY  = 3;

	// ==========================================================
	// Reset values and widths
	localparam int   COUNT_W         = 12;
	localparam logic RST_EMPTY       = 1'b1;
	localparam logic RST_NEAR_EMPTY  = 1'b1;
	localparam logic RST_FULL        = 1'b0;
	localparam logic RST_NEAR_FULL   = 1'b0;
	localparam logic RST_ERR         = 1'b0;
	localparam logic RST_CLK_PREV    = 1'b1;

endpackage

//--- logic/dcf_sync.sv
// Two-stage pointer synchroniser stepped by the destination side's clock edge
`timescale 1ns/10ps
`default_nettype none

module dcf_sync #(
	parameter int W = 10
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic         step,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dcf_sync_s;

	dcf_sync_s s_q;
	dcf_sync_s s_d;

	// ==========================================================
	// Stages
	// Only gray codes pass here, so a late edge shifts a whole value by one step
	always_comb begin
		s_d = s_q;
		if (reset) begin
			s_d = '0;
		end else if (step) begin
			s_d.meta   = d;
			s_d.stable = s_q.meta;
		end
	end

	always_ff @(posedge core_clk) begin
		s_q <= s_d;
	end

	assign q = s_q.stable;

endmodule
`default_nettype wire

//--- tb/dcf_fifo_assertions.sv
// Port-level assertions and covers for the dual-clock FIFO
`timescale 1ns/10ps
`default_nettype none
module dcf_fifo_assertions #(
	parameter int DATA_W = 32,
	parameter int PAR_W  = 4
) (
	input wire logic                        core_clk,
	input wire logic                        reset,
	input wire logic                        write_side_clock,
	input wire logic                        read_side_clock,
	input wire logic [DATA_W-1:0]           read_data_out,
	input wire logic [PAR_W-1:0]            read_parity_out,
	input wire logic                        empty_flag,
	input wire logic                        near_empty_flag,
	input wire logic                        full_flag,
	input wire logic                        near_full_flag,
	input wire logic                        read_underflow_flag,
	input wire logic                        write_overflow_flag,
	input wire logic [dcf_pkg::COUNT_W-1:0] read_pointer_out,
	input wire logic [dcf_pkg::COUNT_W-1:0] write_pointer_out,
	input wire logic                        avs_read,
	input wire logic                        avs_write,
	input wire logic [4:0]                  avs_address,
	input wire logic [31:0]                 avs_writedata,
	input wire logic [3:0]                  avs_byteenable,
	input wire logic                        avs_waitrequest
);
	// ====================
	// Side edges; outputs may move on the edge's cycle or the next one
	logic      wq, rq, we1, re1;
	logic      fl;
	wire logic w_edge = write_side_clock & ~wq;
	wire logic r_edge = read_side_clock & ~rq;
	wire logic w_near = w_edge | we1;
	wire logic r_near = r_edge | re1;
	always_ff @(posedge core_clk) begin
		wq <= write_side_clock;
		rq <= read_side_clock;
		we1 <= w_edge;
		re1 <= r_edge;
	end
	// Flush resets the FIFO side without any side clock edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			fl <= 1'b0;
		end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
			&& avs_address == dcf_pkg::REG_CTRL) begin
			fl <= avs_writedata[dcf_pkg::CTRL_FLUSH_BIT];
		end
	end
	// ====================
	// Properties
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	reset_values_a: assert property (disable iff (1'b0)
		reset |=> empty_flag && near_empty_flag && !(full_flag | near_full_flag)
		&& !(read_underflow_flag | write_overflow_flag)
		&& read_pointer_out == 0 && write_pointer_out == 0)
		else $error("flags or pointers not at reset values");
	rd_side_hold_a: assert property (!r_near && !fl |=>
		$stable({empty_flag, near_empty_flag, read_underflow_flag, read_pointer_out}))
		else $error("read side status moved without a read edge");
	wr_side_hold_a: assert property (!w_near && !fl |=>
		$stable({full_flag, near_full_flag, write_overflow_flag, write_pointer_out}))
		else $error("write side status moved without a write edge");
	rd_data_hold_a: assert property (!r_near && !fl |=>
		$stable({read_data_out, read_parity_out}))
		else $error("read data moved without a read edge");
	underflow_cause_a: assert property ($rose(read_underflow_flag) |->
		empty_flag && $stable(read_data_out))
		else $error("underflow without empty or with data change");
	overflow_cause_a: assert property ($rose(write_overflow_flag) |->
		full_flag && $stable(write_pointer_out))
		else $error("overflow without full or pointer moved");
	wr_ptr_step_a: assert property ($changed(write_pointer_out) |->
		write_pointer_out == $past(write_pointer_out) + 1'b1 || write_pointer_out == 0)
		else $error("write pointer jumped");
	rd_ptr_step_a: assert property ($changed(read_pointer_out) |->
		read_pointer_out == $past(read_pointer_out) + 1'b1 || read_pointer_out == 0)
		else $error("read pointer jumped");
	bus_one_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not exactly one cycle");
	cover property ($rose(write_overflow_flag));
	cover property ($rose(read_underflow_flag));
	cover property ($fell(empty_flag));
endmodule
bind dcf_fifo dcf_fifo_assertions #(.DATA_W(DATA_W), .PAR_W(PAR_W)) chk (
	.core_clk(core_clk), .reset(reset), .write_side_clock(write_side_clock),
	.read_side_clock(read_side_clock), .read_data_out(read_data_out),
	.read_parity_out(read_parity_out), .empty_flag(empty_flag),
	.near_empty_flag(near_empty_flag), .full_flag(full_flag), .near_full_flag(near_full_flag),
	.read_underflow_flag(read_underflow_flag), .write_overflow_flag(write_overflow_flag),
	.read_pointer_out(read_pointer_out), .write_pointer_out(write_pointer_out),
	.avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest));
`default_nettype wire

//--- tb/dcf_user_model.sv
// User logic on the two side clocks, as seen at the FIFO's ports
`timescale 1ns/10ps
`default_nettype none
module dcf_user_model #(
	parameter int HALF = 3
) (
	input  wire logic        core_clk,
	input  wire logic        wr_go,
	input  wire logic [35:0] wr_word,
	input  wire logic        rd_go,
	output logic             wr_ack = 1'b0,
	output logic             rd_ack = 1'b0,
	output logic             write_side_clock = 1'b1,
	output logic [31:0]      write_data_in = 32'h0,
	output logic [3:0]       write_parity_in = 4'h0,
	output logic             write_enable_in = 1'b0,
	output logic             read_side_clock = 1'b1,
	output logic             read_enable_in = 1'b0
);
	// ====================
	// Unequal half periods make the two clocks drift against each other
	int wc = 0;
	int rc = 0;
	always @(posedge core_clk) begin
		wc <= (wc == HALF - 1) ? 0 : wc + 1;
		rc <= (rc == HALF) ? 0 : rc + 1;
		wr_ack <= 1'b0;
		rd_ack <= 1'b0;
		if (wc == HALF - 1) begin
			write_side_clock <= !write_side_clock;
			if (write_side_clock) begin
				// Moves only on the falling phase; idle data toggles so stale words show
				write_enable_in <= wr_go;
				write_data_in <= wr_go ? wr_word[31:0] : ~write_data_in;
				write_parity_in <= wr_go ? wr_word[35:32] : ~write_parity_in;
				wr_ack <= wr_go;
			end
		end
		if (rc == HALF) begin
			read_side_clock <= !read_side_clock;
			if (read_side_clock) begin
				read_enable_in <= rd_go;
				rd_ack <= rd_go;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench: standard mode against a queue model, fall-through mode on its first word
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ====================
	// Signals; a 16-deep FIFO keeps the fill short
	localparam int AW = 4;
	logic        core_clk = 1'b0, reset = 1'b1, wr_go = 1'b0, rd_go = 1'b0;
	logic        a_rd = 1'b0, a_wr = 1'b0, pw = 1'b1, pr = 1'b1, wrose = 1'b0;
	logic        wr_ack, rd_ack, wsc, rsc, we, re, e0, e1, ne0, f0, nf0, ue0, oe0, wt, irq0;
	logic [35:0] wr_word = 36'h0, w;
	logic [31:0] a_wd = 32'h0, seed = 32'he85d68bf, wd, rd0, rd1, rdat, got;
	logic [4:0]  adr = 5'h0;
	logic [3:0]  a_be = 4'h0, wp, pp0, pp1;
	logic [11:0] rp0, wp0;
	logic [35:0] q[$];
	int          err_total = 0, n_checks = 0, i, k, n = 0, n0 = 0, n1 = 0;
	always #10 core_clk = ~core_clk;
	dcf_user_model #(.HALF(3)) pm (.core_clk(core_clk), .wr_go(wr_go), .wr_word(wr_word),
		.rd_go(rd_go), .wr_ack(wr_ack), .rd_ack(rd_ack), .write_side_clock(wsc),
		.write_data_in(wd), .write_parity_in(wp), .write_enable_in(we),
		.read_side_clock(rsc), .read_enable_in(re));
	dcf_fifo #(.ADDR_W(AW), .first_word_fallthrough_mode(1'b0)) uut (
		.core_clk(core_clk), .reset(reset), .write_side_clock(wsc), .write_data_in(wd),
		.write_parity_in(wp), .write_enable_in(we), .read_side_clock(rsc),
		.read_enable_in(re), .read_data_out(rd0), .read_parity_out(pp0), .empty_flag(e0),
		.near_empty_flag(ne0), .full_flag(f0), .near_full_flag(nf0),
		.read_underflow_flag(ue0), .write_overflow_flag(oe0), .read_pointer_out(rp0),
		.write_pointer_out(wp0), .avs_address(adr), .avs_read(a_rd), .avs_write(a_wr),
		.avs_writedata(a_wd), .avs_byteenable(a_be), .avs_readdata(rdat),
		.avs_waitrequest(wt), .irq(irq0));
	dcf_fifo #(.ADDR_W(AW), .first_word_fallthrough_mode(1'b1)) uut_fw (
		.core_clk(core_clk), .reset(reset), .write_side_clock(wsc), .write_data_in(wd),
		.write_parity_in(wp), .write_enable_in(we), .read_side_clock(rsc),
		.read_enable_in(re), .read_data_out(rd1), .read_parity_out(pp1), .empty_flag(e1),
		.near_empty_flag(), .full_flag(), .near_full_flag(), .read_underflow_flag(),
		.write_overflow_flag(), .read_pointer_out(), .write_pointer_out(),
		.avs_address(adr), .avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd),
		.avs_byteenable(a_be), .avs_readdata(), .avs_waitrequest(), .irq());
	// ====================
	// Tasks
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task lim(input int c);
		if (c >= 100) begin
			err_total++;
			end_sim();
		end
	endtask
	// Waits past the next rising edge of a side clock and lets the outputs settle
	task rise(input logic r);
		for (k = 0; k < 100 && (r ? rsc : wsc); k++) @(posedge core_clk);
		for (; k < 100 && !(r ? rsc : wsc); k++) @(posedge core_clk);
		lim(k);
		repeat (3) @(posedge core_clk);
	endtask
	task hs(input logic r, input logic [35:0] v);
		rd_go <= r;
		wr_go <= !r;
		wr_word <= v;
		for (k = 0; k < 100; k++) begin
			@(posedge core_clk);
			if (r ? rd_ack : wr_ack) break;
		end
		lim(k);
		rd_go <= 1'b0;
		wr_go <= 1'b0;
		rise(r);
	endtask
	task avs(input logic wr, input logic [4:0] ad, input logic [31:0] dat);
		adr <= ad;
		a_wd <= dat;
		a_be <= {4{wr}};
		a_rd <= !wr;
		a_wr <= wr;
		for (k = 0; k < 100; k++) begin
			@(posedge core_clk);
			if (wt === 1'b0) break;
		end
		lim(k);
		got = rdat;
		a_rd <= 1'b0;
		a_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// ====================
	// Sequence
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		check("empty", {e0, ne0, e1}, 3'h7);
		check("flags", {f0, nf0, ue0, oe0, rp0, wp0}, 28'h0);
		avs(1'b0, dcf_pkg::REG_FLAGS, 32'h0);
		check("flag_reg", got, 32'h3);
		avs(1'b0, 5'h1c, 32'h0);
		check("unmapped", got, 32'h0);
		avs(1'b1, dcf_pkg::REG_IRQ_ENABLE, 32'h1);
		avs(1'b0, dcf_pkg::REG_IRQ_ENABLE, 32'h0);
		check("irq_enable", got, 32'h1);
		seed = xs(seed);
		w = {seed[7:4], seed};
		q.push_back(w);
		wr_go <= 1'b1;
		wr_word <= w;
		// Count read edges after the write edge until each empty falls
		for (k = 0; k < 100 && (n0 == 0 || n1 == 0); k++) begin
			@(posedge core_clk);
			if (wr_ack) wr_go <= 1'b0;
			if (wrose && rsc && !pr) n++;
			if (wsc && !pw && we) wrose = 1'b1;
			if (!e0 && n0 == 0) n0 = n;
			if (!e1 && n1 == 0) n1 = n;
			pw = wsc;
			pr = rsc;
		end
		lim(k);
		check("std_latency", n0 == 3 || n0 == 4, 1'b1);
		check("fw_latency", n1 == 4 || n1 == 5, 1'b1);
		check("fw_word", {pp1, rd1}, w);
		check("std_word", {pp0, rd0}, 36'h0);
		for (i = 1; i <= 16; i++) begin
			seed = xs(seed);
			w = {seed[7:4], seed};
			if (i < 16) q.push_back(w);
			hs(1'b0, w);
		end
		check("full", {f0, nf0, oe0, irq0, ne0, wp0}, {5'h1e, 12'(q.size())});
		avs(1'b0, dcf_pkg::REG_IRQ_STATUS, 32'h0);
		check("irq_status", got[dcf_pkg::IRQ_OVERFLOW], 1'b1);
		rise(1'b0);
		check("overflow_off", oe0, 1'b0);
		avs(1'b1, dcf_pkg::REG_IRQ_CLEAR, 32'h1);
		check("irq_clear", irq0, 1'b0);
		for (i = 1; q.size() > 0; i++) begin
			w = q.pop_front();
			hs(1'b1, 36'h0);
			check("word", {pp0, rd0}, w);
			check("rd_ptr", rp0, 12'(i));
		end
		hs(1'b1, 36'h0);
		check("underflow", {ue0, e0}, 2'h3);
		check("held_word", {pp0, rd0}, w);
		avs(1'b0, dcf_pkg::REG_POINTERS, 32'h0);
		check("pointers", got, 32'h00100010);
		avs(1'b0, dcf_pkg::REG_IRQ_STATUS, 32'h0);
		check("irq_events", got, 32'he);
		// Flush holds the FIFO in its reset state while the registers keep theirs
		avs(1'b1, dcf_pkg::REG_CTRL, 32'h1);
		avs(1'b0, dcf_pkg::REG_FLAGS, 32'h0);
		check("flush_reg", got, 32'h3);
		check("flush_pins", {e0, ne0, f0, nf0, ue0, oe0, rp0, wp0}, {2'h3, 28'h0});
		avs(1'b0, dcf_pkg::REG_CTRL, 32'h0);
		check("ctrl_reg", got, 32'h1);
		avs(1'b1, dcf_pkg::REG_CTRL, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
